// [snv_map.svh]
// offsets, field positions, opcodes and reset values of the serial memory front end
`ifndef SNV_MAP_SVH
`define SNV_MAP_SVH

// opcodes, sent most significant bit first
`define SNV_OP_SET_LATCH 8'h06
`define SNV_OP_CLEAR_LATCH 8'h04
`define SNV_OP_STATUS_READ 8'h05
`define SNV_OP_STATUS_WRITE 8'h01
`define SNV_OP_ARRAY_READ 8'h03
`define SNV_OP_ARRAY_WRITE 8'h02
`define SNV_OP_IDENTITY_READ 8'h9F

// array geometry
`define SNV_ADDR_W 11
`define SNV_WORDS 2048
`define SNV_ADDR_LAST_BYTE 2'h1
`define SNV_ID_LAST_BYTE 2'h3
`define SNV_BIT_LAST 3'h7

// protection_status field positions
`define SNV_BIT_GUARD 7
`define SNV_BIT_SPARE_HI 6
`define SNV_BIT_SPARE_LO 4
`define SNV_BIT_RANGE_HI 3
`define SNV_BIT_RANGE_LO 2
`define SNV_BIT_LATCH 1
`define SNV_BIT_ZERO 0
`define SNV_NV_MASK 8'hFC
`define SNV_STATUS_INIT 8'h00

// protect range encodings
`define SNV_RANGE_NONE 2'h0
`define SNV_RANGE_QUARTER 2'h1
`define SNV_RANGE_HALF 2'h2
`define SNV_RANGE_ALL 2'h3

`endif

// [snv_pkg.sv]
// types shared by the serial memory front end
package snv_pkg;

  typedef enum logic [3:0] {
    st_opcode,
    st_raddr,
    st_waddr,
    st_array_read,
    st_array_write,
    st_status_read,
    st_status_write,
    st_id_read,
    st_ignore
  } snv_state_t;

endpackage : snv_pkg

// [snv_front_end.sv]
// spi slave front end of a 2048 x 8 nonvolatile serial memory
//
// Notes on behaviour
// [R01] chip select high: standby, output floats, inputs ignored
// [R02] master lowers select before opcode, holds it
// [R03] hold low suspends transfer, floats output
// [R04] master keeps select low during hold
// [R05] sample input on rise, drive output on fall
// [R06] works in spi modes 0 and 3
// [R07] array of 2048 bytes, kept without power
// [R08] array write finishes inside transfer, no busy
// [R09] bit 7 status guard enable, read/write
// [R10] bits 6 to 4 plain nonvolatile storage
// [R11] bits 3 and 2 select protect range
// [R12] bit 1 latch: set/clear commands only
// [R13] writes allowed only while latch set
// [R14] latch cleared at reset, clear, write-ending deselect
// [R15] bit 0 reads zero, never written
// [R16] eight bit opcodes msb first, deselect cancels
// [R17] address sixteen bits, auto increment with wrap
// [R18] range 00 none, 01 quarter, 10 half, 11 all
// [R19] guard plus low pin blocks status write
// [R20] every deselect restarts opcode decoding
// [R21] unknown opcode ignored until deselect
`timescale 1ns/1ps
`include "snv_map.svh"

module snv_front_end #(
  // arbitrary neutral identity word
  parameter logic [31:0] ID_WORD = 32'h0102_0304
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe,
  output logic latch_state,
  output logic selected
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and system clock crossings

  logic rst_q1_reg;
  logic rst_q2_reg;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1_reg <= 1'b0;
      rst_q2_reg <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_q2_reg <= rst_q1_reg;
    end
  end

  assign rst_sync_n = rst_q2_reg;

  // toggles from the link domain, plus select, each through two flops
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] link_lvl;
  logic set_tgl_reg;
  logic clr_tgl_reg;
  logic arm_tgl_reg;

  assign link_lvl = {~cs_n, arm_tgl_reg, clr_tgl_reg, set_tgl_reg};

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= link_lvl;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write enable latch, kept in the system domain

  // the latch must survive deselect, so it cannot sit in the link state
  logic wel_reg;
  logic wel_next;
  logic armed_reg;
  logic armed_next;
  logic set_ev;
  logic clr_ev;
  logic arm_ev;
  logic cs_rise;

  always_comb begin
    set_ev = sync2_reg[0] ^ sync3_reg[0];
    clr_ev = sync2_reg[1] ^ sync3_reg[1];
    arm_ev = sync2_reg[2] ^ sync3_reg[2];
    cs_rise = sync3_reg[3] & ~sync2_reg[3];
    wel_next = wel_reg;
    armed_next = armed_reg;
    if (cs_rise) begin
      armed_next = 1'b0;
      if (armed_reg || arm_ev) begin
        wel_next = 1'b0; // see [R14]
      end
    end else if (arm_ev) begin
      armed_next = 1'b1;
    end
    if (clr_ev) begin
      wel_next = 1'b0; // see [R14]
    end
    // a set arriving with a clear is not lost
    if (set_ev) begin
      wel_next = 1'b1; // see [R12]
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wel_reg <= 1'b0; // see [R14]
      armed_reg <= 1'b0;
    end else begin
      wel_reg <= wel_next;
      armed_reg <= armed_next;
    end
  end

  assign latch_state = wel_reg;
  assign selected = sync2_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // link domain: level crossings into sck

  // sck runs at least one opcode before these are read, so two edges suffice
  logic wel_s1_reg;
  logic wel_s2_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;

  always_ff @(posedge sck or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wel_s1_reg <= 1'b0;
      wel_s2_reg <= 1'b0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end else begin
      wel_s1_reg <= wel_reg;
      wel_s2_reg <= wel_s1_reg;
      wp_s1_reg <= wp_n;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: command decoder on the rising edge

  function automatic logic snv_protected(
    input logic [1:0] range,
    input logic [`SNV_ADDR_W-1:0] addr
  );
    unique case (range)
      `SNV_RANGE_NONE: snv_protected = 1'b0;
      `SNV_RANGE_QUARTER: snv_protected = &addr[10:9];
      `SNV_RANGE_HALF: snv_protected = addr[10];
      `SNV_RANGE_ALL: snv_protected = 1'b1;
    endcase
  endfunction : snv_protected

  // deselect clears the decoder at once, without waiting for sck
  logic link_clr;

  assign link_clr = cs_n | ~rst_sync_n; // see [R01] see [R20]

  snv_pkg::snv_state_t state_reg;
  snv_pkg::snv_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [1:0] byte_idx_reg;
  logic [1:0] byte_idx_next;
  logic [`SNV_ADDR_W-1:0] addr_reg;
  logic [`SNV_ADDR_W-1:0] addr_next;
  logic id_done_reg;
  logic id_done_next;
  logic [7:0] status_nv_reg;
  logic [7:0] status_nv_next;
  logic set_tgl_next;
  logic clr_tgl_next;
  logic arm_tgl_next;
  logic [7:0] in_byte;
  logic byte_end;
  logic mem_we;
  logic status_ok;

  always_comb begin
    in_byte = {shift_reg[6:0], si}; // see [R16]
    byte_end = (bit_cnt_reg == `SNV_BIT_LAST);
    // guard bit with the pin low shields the status register
    status_ok = wel_s2_reg
      & ~(status_nv_reg[`SNV_BIT_GUARD] & ~wp_s2_reg); // see [R19] see [R09]
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    addr_next = addr_reg;
    id_done_next = id_done_reg;
    status_nv_next = status_nv_reg;
    set_tgl_next = set_tgl_reg;
    clr_tgl_next = clr_tgl_reg;
    arm_tgl_next = arm_tgl_reg;
    mem_we = 1'b0;
    // hold freezes everything; sck and si are don't care meanwhile
    if (hold_n) begin // see [R03]
      shift_next = in_byte; // see [R05]
      bit_cnt_next = bit_cnt_reg + 3'h1;
      if (byte_end) begin
        byte_idx_next = byte_idx_reg + 2'h1;
      end
      unique case (state_reg)
        snv_pkg::st_opcode: begin
          if (byte_end) begin
            byte_idx_next = 2'h0;
            case (in_byte) // see [R16]
              `SNV_OP_SET_LATCH: begin
                set_tgl_next = ~set_tgl_reg; // see [R12]
                state_next = snv_pkg::st_ignore;
              end
              `SNV_OP_CLEAR_LATCH: begin
                clr_tgl_next = ~clr_tgl_reg; // see [R14]
                state_next = snv_pkg::st_ignore;
              end
              `SNV_OP_STATUS_READ: state_next = snv_pkg::st_status_read;
              `SNV_OP_STATUS_WRITE: begin
                arm_tgl_next = ~arm_tgl_reg; // see [R14]
                state_next = snv_pkg::st_status_write;
              end
              `SNV_OP_ARRAY_READ: state_next = snv_pkg::st_raddr;
              `SNV_OP_ARRAY_WRITE: begin
                arm_tgl_next = ~arm_tgl_reg; // see [R14]
                state_next = snv_pkg::st_waddr;
              end
              `SNV_OP_IDENTITY_READ: state_next = snv_pkg::st_id_read;
              default: state_next = snv_pkg::st_ignore; // see [R21]
            endcase
          end
        end
        snv_pkg::st_raddr, snv_pkg::st_waddr: begin
          if (byte_end) begin
            // upper five address bits fall off the top
            addr_next = {addr_reg[2:0], in_byte}; // see [R17]
            if (byte_idx_reg == `SNV_ADDR_LAST_BYTE) begin
              if (state_reg == snv_pkg::st_waddr) begin
                state_next = snv_pkg::st_array_write;
              end else begin
                state_next = snv_pkg::st_array_read;
              end
            end
          end
        end
        snv_pkg::st_array_write: begin
          if (byte_end) begin
            // write lands on this edge, so no busy time follows
            mem_we = wel_s2_reg
              & ~snv_protected(status_nv_reg[3:2], addr_reg); // see [R08] see [R13] see [R18]
            addr_next = addr_reg + 11'h001; // see [R17]
          end
        end
        snv_pkg::st_array_read: begin
          if (byte_end) begin
            addr_next = addr_reg + 11'h001; // see [R17]
          end
        end
        snv_pkg::st_status_write: begin
          if (byte_end) begin
            if (status_ok) begin // see [R13]
              status_nv_next = in_byte & `SNV_NV_MASK; // see [R10] see [R11] see [R15]
            end
            state_next = snv_pkg::st_ignore;
          end
        end
        snv_pkg::st_id_read: begin
          if (byte_end && byte_idx_reg == `SNV_ID_LAST_BYTE) begin
            id_done_next = 1'b1;
          end
        end
        snv_pkg::st_status_read, snv_pkg::st_ignore: begin
        end
      endcase
    end
  end

  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      state_reg <= snv_pkg::st_opcode; // see [R20]
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 2'h0;
      addr_reg <= 11'h000;
      id_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      addr_reg <= addr_next;
      id_done_reg <= id_done_next;
    end
  end

  // status storage and event toggles must outlive deselect
  always_ff @(posedge sck or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_nv_reg <= `SNV_STATUS_INIT;
      set_tgl_reg <= 1'b0;
      clr_tgl_reg <= 1'b0;
      arm_tgl_reg <= 1'b0;
    end else begin
      status_nv_reg <= status_nv_next;
      set_tgl_reg <= set_tgl_next;
      clr_tgl_reg <= clr_tgl_next;
      arm_tgl_reg <= arm_tgl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory array, flops with no reset so contents survive

  logic [7:0] mem_reg [0:`SNV_WORDS-1];

  always_ff @(posedge sck) begin
    if (mem_we) begin
      mem_reg[addr_reg] <= in_byte; // see [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output on the falling edge

  logic so_reg;
  logic so_next;
  logic drive_reg;
  logic drive_next;
  logic [7:0] rd_byte;
  logic [4:0] id_pos;

  always_comb begin
    rd_byte = mem_reg[addr_reg];
    if (state_reg == snv_pkg::st_status_read) begin
      rd_byte = {status_nv_reg[7:2], wel_s2_reg, 1'b0}; // see [R12] see [R15]
    end
    id_pos = ~{byte_idx_reg, bit_cnt_reg};
    so_next = so_reg;
    drive_next = drive_reg;
    if (hold_n) begin // see [R03]
      unique case (state_reg)
        snv_pkg::st_array_read, snv_pkg::st_status_read: begin
          drive_next = 1'b1;
          so_next = rd_byte[~bit_cnt_reg]; // see [R05]
        end
        snv_pkg::st_id_read: begin
          drive_next = 1'b1;
          // the last identity bit stands until deselect
          if (!id_done_reg) begin
            so_next = ID_WORD[id_pos];
          end
        end
        default: begin
          drive_next = 1'b0;
        end
      endcase
    end
  end

  // in mode 3 the falling edge at select finds the decoder idle, harmless
  always_ff @(negedge sck or posedge link_clr) begin // see [R06]
    if (link_clr) begin
      so_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      so_reg <= so_next;
      drive_reg <= drive_next;
    end
  end

  assign so_out = so_reg;
  assign so_oe = ~cs_n & hold_n & drive_reg; // see [R01] see [R03]

endmodule : snv_front_end

// [snv_front_end_asserts.sv]
// port-level checks of the serial memory front end
`timescale 1ns/1ps
module snv_front_end_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic latch_state,
  input wire logic selected
);
  // clocks since the synchronised select dropped, saturating
  logic [3:0] idle_reg;
  logic [3:0] idle_next;
  always_comb begin
    idle_next = idle_reg + {3'h0, idle_reg != 4'hF};
    if (selected) begin
      idle_next = 4'h0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= 4'hF;
    end else begin
      idle_reg <= idle_next;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence desel_held;
    cs_n [*3];
  endsequence
  sequence sel_held;
    !cs_n [*3];
  endsequence
  chk_cs_float: assert property (cs_n |-> !so_oe)
    else $error("output on while deselected");
  chk_hold_float: assert property (!hold_n |-> !so_oe)
    else $error("output on during hold");
  chk_desel_idle: assert property (desel_held |-> !selected)
    else $error("selected flag stuck high");
  chk_sel_seen: assert property (sel_held |-> selected)
    else $error("selected flag late");
  chk_so_on_fall: assert property ($changed(so_out) |-> $fell(sck) || cs_n || $past(cs_n))
    else $error("serial out moved off a falling edge");
  chk_oe_on_fall: assert property ($rose(so_oe) |-> $fell(sck) || $rose(hold_n))
    else $error("output enable rose off a falling edge");
  // latch only moves on a command or the deselect that ends a write
  chk_latch_quiet: assert property ($changed(latch_state) |-> idle_reg < 4'h8)
    else $error("latch moved while idle");
  chk_latch_reset: assert property (disable iff (1'b0) !rst_n |-> !latch_state && !selected)
    else $error("latch or select set in reset");
endmodule : snv_front_end_asserts

// [snv_spi_master.sv]
// spi master model that drives the serial memory front end
`timescale 1ns/1ps
module snv_spi_master (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so_out,
  input wire logic so_oe
);
  logic cpol;
  logic held_oe;
  initial begin
    cpol = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    held_oe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // sck only runs inside a frame; si set while sck low so it is steady at the rise
  task automatic xfer(input int n, input int hb, input logic [63:0] tx, output logic [63:0] rx);
    rx = 64'h0;
    // a mode change moves sck to its idle level before select, never in the same step
    if (sck !== cpol) begin
      sck = cpol;
      #32;
    end
    cs_n = 1'b0;
    #32;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      #32;
      if (i == hb) begin
        hold_n = 1'b0;
        repeat (2) begin
          sck = 1'b1;
          si = ~si;
          #32;
          sck = 1'b0;
          #32;
        end
        held_oe = so_oe;
        si = tx[i];
        hold_n = 1'b1;
        #32;
      end
      sck = 1'b1;
      rx[i] = so_oe ? so_out : 1'bx;
      #32;
    end
    sck = cpol;
    #32;
    cs_n = 1'b1;
    si = ~si;
    #100;
  endtask : xfer
endmodule : snv_spi_master

// [tb_top.sv]
// self-checking bench for the serial memory front end
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] ID = 32'hA1B2_C3D4; // arbitrary value
  logic clock, rst_n, wp_n, cs_n, sck, si, hold_n, so_out, so_oe, latch_state, selected;
  logic [63:0] rx;
  logic [15:0] a;
  int error_cnt = 0;
  int checked = 0;
  snv_front_end #(.ID_WORD(ID)) snv_front_end_i (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
    .latch_state(latch_state), .selected(selected));
  snv_spi_master snv_spi_master_i (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe));
  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic go(input int n, input logic [63:0] tx, input int hb = -1);
    @(posedge clock);
    #1.3;
    snv_spi_master_i.xfer(n, hb, tx, rx);
  endtask : go
  task automatic wr_st(input logic [7:0] v);
    go(8, 64'h06);
    go(16, {48'h0, 8'h01, v});
  endtask : wr_st
  task automatic wr_mem(input logic [15:0] adr, input logic [15:0] d);
    go(8, 64'h06);
    go(40, {24'h0, 8'h02, adr, d});
  endtask : wr_mem
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  task automatic t_latch;
    check("latch", latch_state, 1'b0);
    go(16, 64'h0500);
    check("status", rx[7:0], 8'h00);
    go(8, 64'h06);
    check("latch", latch_state, 1'b1);
    go(8, 64'hA5);
    check("latch", latch_state, 1'b1);
    go(16, 64'h0500);
    check("status", rx[7:0], 8'h02);
    // a cut opcode must not run into the next one
    go(4, 64'h0);
    go(8, 64'h04);
    check("latch", latch_state, 1'b0);
    $display("latch test done");
  endtask : t_latch
  task automatic t_status;
    wr_st(8'hFF);
    check("latch", latch_state, 1'b0);
    go(16, 64'h0500);
    check("status", rx[7:0], 8'hFC);
    @(posedge clock);
    #1.3;
    wp_n = 1'b0;
    wr_st(8'h00);
    go(16, 64'h0500);
    check("status", rx[7:0], 8'hFC);
    @(posedge clock);
    #1.3;
    wp_n = 1'b1;
    go(16, 64'h0100);
    go(16, 64'h0500);
    check("status", rx[7:0], 8'hFC);
    wr_st(8'h00);
    go(16, 64'h0500);
    check("status", rx[7:0], 8'h00);
    $display("status test done");
  endtask : t_status
  task automatic t_protect;
    for (int r = 1; r < 4; r++) begin
      a = (r == 1) ? 16'h05FF : (r == 2) ? 16'h03FF : 16'h07FF;
      wr_st(8'h00);
      wr_mem(a, 16'h1122);
      wr_st({4'h0, r[1:0], 2'h0});
      wr_mem(a, 16'hABCD);
      go(40, {24'h0, 8'h03, a, 16'h0});
      check("mem", rx[15:0], (r == 3) ? 16'h1122 : 16'hAB22);
    end
    wr_st(8'h00);
    $display("protect test done");
  endtask : t_protect
  task automatic t_mode3;
    snv_spi_master_i.cpol = 1'b1;
    wr_mem(16'hFFFF, 16'h5AA5);
    go(40, {24'h0, 8'h02, 16'h07FF, 16'h0});
    go(40, {24'h0, 8'h03, 16'hF7FF, 16'h0});
    check("mem", rx[15:0], 16'h5AA5);
    snv_spi_master_i.cpol = 1'b0;
    $display("mode 3 test done");
  endtask : t_mode3
  task automatic t_hold_id;
    wr_mem(16'h0123, 16'h3CC3);
    go(40, {24'h0, 8'h03, 16'h0123, 16'h0}, 12);
    check("mem", rx[15:0], 16'h3CC3);
    check("oe", snv_spi_master_i.held_oe, 1'b0);
    go(40, {24'h0, 8'h9F, 32'h0});
    check("ident", rx[31:0], ID);
    check("oe", so_oe, 1'b0);
    $display("hold and identity test done");
  endtask : t_hold_id
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (5) @(posedge clock);
    #1.3;
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
    t_latch();
    t_status();
    t_protect();
    t_mode3();
    t_hold_id();
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_top
bind snv_front_end snv_front_end_asserts snv_front_end_asserts_i (.clock(clock), .rst_n(rst_n),
  .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe),
  .latch_state(latch_state), .selected(selected));
